/* File: ftp_pkg.sv */
// package for the flash tristate port: timing units, sizes and cycle conversion
// assumes a single core clock whose rate is given below
package ftp_pkg;
    localparam int CLK_HZ = 25000000;
    localparam int CLK_PERIOD_PS = 40000;
    localparam logic [1:0] UNIT_NS = 2'h0;
    localparam logic [1:0] UNIT_US = 2'h1;
    localparam logic [1:0] UNIT_MS = 2'h2;
    localparam logic [1:0] UNIT_CYC = 2'h3;
    localparam int PS_PER_NS = 1000;
    localparam int PS_PER_US = 1000000;
    localparam int PS_PER_MS = 1000000000;
    localparam int ADDR_W_DEF = 22;
    localparam int DATA_W_DEF = 8;
    localparam int SETUP_DEF = 40;
    localparam int WAIT_DEF = 160;
    localparam int HOLD_DEF = 40;
    localparam int CNT_W = 24;

    typedef enum logic [2:0] {
        FTP_IDLE = 3'b000,
        FTP_SETUP = 3'b001,
        FTP_STROBE = 3'b010,
        FTP_HOLD = 3'b011,
        FTP_DONE = 3'b100
    } ftp_state_type;

    // time in units to whole cycles, rounded up, at least one
    function automatic int ftp_cycles(input logic [1:0] unit, input int value);
        longint ps;
        longint c;
        ps = 0;
        c = 0;
        if (unit == UNIT_CYC) begin
            c = value;
        end else begin
            if (unit == UNIT_NS) ps = longint'(value) * PS_PER_NS;
            else if (unit == UNIT_US) ps = longint'(value) * PS_PER_US;
            else ps = longint'(value) * PS_PER_MS;
            c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        end
        if (c < 1) c = 1;
        return int'(c);
    endfunction : ftp_cycles
endpackage : ftp_pkg

/* File: ftp_phase_if.sv */
// timer handshake between the sequencer and its phase counter
`timescale 1ns/1ps
interface ftp_phase_if;
    import ftp_pkg::*;
    logic load;
    logic [CNT_W-1:0] count;
    logic expired;
    modport seq (output load, output count, input expired);
    modport tmr (input load, input count, output expired);
endinterface : ftp_phase_if

/* File: ftp_phase_timer.sv */
// down counter timing one phase of a flash access
// assumes load is a one-cycle pulse carrying a count of at least one
`timescale 1ns/1ps
module ftp_phase_timer
    import ftp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    ftp_phase_if.tmr tif
);
    typedef struct packed {
        logic [CNT_W-1:0] left;
        logic run;
    } ftp_tmr_type;

    ftp_tmr_type st_reg;
    ftp_tmr_type st_next;

    always_comb begin
        st_next = st_reg;
        if (tif.load) begin
            st_next.left = tif.count;
            st_next.run = 1'b1;
        end else if (st_reg.run) begin
            st_next.left = st_reg.left - CNT_W'(1);
            if (st_reg.left == CNT_W'(1)) st_next.run = 1'b0;
        end
    end

    assign tif.expired = st_reg.run && (st_reg.left == CNT_W'(1));

    always_ff @(posedge i_clk) begin
        if (i_rst) st_reg <= '0;
        else st_reg <= st_next;
    end
endmodule : ftp_phase_timer

/* File: ftp_port.sv */
// flash tristate port: system-side memory slave driving a shared tristate flash bus
// assumes the shared address/data pins are muxed by the bridge; chip select and
// strobes are this port's own; inputs are synchronous to I_CORE_CLK
// Functional notes
// RQ1: tristate slave doing reads and writes, fixed timing
// RQ2: masters read flash as plain memory
// RQ3: parameter sets flash address width
// RQ4: parameter sets flash data width
// RQ5: claimed window spans exactly flash capacity
// RQ6: width adapter joins wider masters to flash
// RQ7: setup time from select to strobe
// RQ8: strobe held for wait time
// RQ9: select held for hold time after strobe
// RQ10: shared units parameter for all durations
// RQ11: own select and strobes, shared pins
// RQ12: time units round up to whole cycles
`timescale 1ns/1ps
module ftp_port
    import ftp_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF,
    parameter int HOST_W = 32,
    parameter logic [1:0] UNITS = UNIT_NS,
    parameter int SETUP_T = SETUP_DEF,
    parameter int WAIT_T = WAIT_DEF,
    parameter int HOLD_T = HOLD_DEF
) (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire logic [ADDR_W+$clog2(DATA_W/8)-1:0] I_ADDR,
    input wire logic I_READ,
    input wire logic I_WRITE,
    input wire logic [HOST_W-1:0] I_WDATA,
    input wire logic [HOST_W/8-1:0] I_BE,
    output logic [HOST_W-1:0] O_RDATA,
    output logic O_WAITREQ,
    output logic O_RVALID,
    output logic [ADDR_W-1:0] O_FL_ADDR,
    output logic [DATA_W-1:0] O_FL_DQ,
    output logic O_FL_DQ_OE,
    input wire logic [DATA_W-1:0] I_FL_DQ,
    output logic O_FL_CS_N,
    output logic O_FL_RD_N,
    output logic O_FL_WR_N
);
    localparam int BEATS = HOST_W / DATA_W;
    localparam int BW = (BEATS > 1) ? $clog2(BEATS) : 1;
    localparam int LANE_B = DATA_W / 8;
    localparam int LSB_W = $clog2(LANE_B);
    localparam int HLSB_W = $clog2(HOST_W / 8);
    // flash capacity in bytes is 2**(ADDR_W+LSB_W); the host address spans it
    localparam int WIN_W = ADDR_W + LSB_W; // RQ5
    localparam logic [CNT_W-1:0] SETUP_C = CNT_W'(ftp_cycles(UNITS, SETUP_T)); // RQ10 RQ12
    localparam logic [CNT_W-1:0] WAIT_C = CNT_W'(ftp_cycles(UNITS, WAIT_T)); // RQ10 RQ12
    localparam logic [CNT_W-1:0] HOLD_C = CNT_W'(ftp_cycles(UNITS, HOLD_T)); // RQ10 RQ12

    typedef struct packed {
        ftp_state_type state;
        logic is_wr;
        logic [BW-1:0] beat;
        logic [BW-1:0] last;
        logic [ADDR_W-1:0] base;
        logic [HOST_W-1:0] wdata;
        logic [HOST_W/8-1:0] be;
        logic [HOST_W-1:0] rdata;
        logic rvalid;
        logic cs;
        logic rd;
        logic wr;
        logic oe;
        logic [ADDR_W-1:0] fl_addr;
        logic [DATA_W-1:0] fl_dq;
    } ftp_port_type;

    ftp_port_type st_reg;
    ftp_port_type st_next;
    ftp_phase_if tif ();

    ftp_phase_timer u_timer (
        .i_clk(I_CORE_CLK),
        .i_rst(I_SYS_RST),
        .tif(tif)
    );

    // byte enables of one flash beat
    function automatic logic beat_active(input logic [HOST_W/8-1:0] be, input int b);
        logic any;
        any = 1'b0;
        for (int k = 0; k < LANE_B; k++) begin
            any = any | be[b * LANE_B + k];
        end
        return any;
    endfunction : beat_active

    // flash word address of a host address
    function automatic logic [ADDR_W-1:0] word_addr(input logic [WIN_W-1:0] a);
        return a[WIN_W-1:LSB_W];
    endfunction : word_addr

    always_comb begin
        st_next = st_reg;
        st_next.rvalid = 1'b0;
        tif.load = 1'b0;
        tif.count = SETUP_C;
        unique case (st_reg.state)
            FTP_IDLE: begin
                if (I_READ || I_WRITE) begin
                    st_next.is_wr = I_WRITE && !I_READ; // RQ1
                    st_next.wdata = I_WDATA;
                    st_next.be = I_READ ? '1 : I_BE;
                    // host word split into flash beats, lowest first
                    st_next.base = word_addr(WIN_W'({I_ADDR[WIN_W-1:HLSB_W], {HLSB_W{1'b0}}})); // RQ6
                    st_next.beat = '0;
                    st_next.last = BW'(BEATS - 1); // RQ6
                    st_next.fl_addr = st_next.base;
                    st_next.cs = 1'b1; // RQ11
                    st_next.oe = st_next.is_wr;
                    st_next.fl_dq = I_WDATA[DATA_W-1:0];
                    st_next.state = FTP_SETUP;
                    tif.load = 1'b1;
                    tif.count = SETUP_C; // RQ7
                end
            end
            FTP_SETUP: begin
                if (tif.expired) begin
                    // masked beat of a narrow write: no strobe, select only
                    st_next.rd = !st_reg.is_wr; // RQ2 RQ7
                    st_next.wr = st_reg.is_wr && beat_active(st_reg.be, int'(st_reg.beat)); // RQ7
                    st_next.state = FTP_STROBE;
                    tif.load = 1'b1;
                    tif.count = WAIT_C; // RQ8
                end
            end
            FTP_STROBE: begin
                if (tif.expired) begin
                    st_next.rd = 1'b0; // RQ8
                    st_next.wr = 1'b0; // RQ8
                    if (!st_reg.is_wr) begin
                        for (int b = 0; b < BEATS; b++) begin
                            if (st_reg.beat == BW'(b)) begin
                                st_next.rdata[b*DATA_W +: DATA_W] = I_FL_DQ; // RQ6
                            end
                        end
                    end
                    st_next.state = FTP_HOLD;
                    tif.load = 1'b1;
                    tif.count = HOLD_C; // RQ9
                end
            end
            FTP_HOLD: begin
                if (tif.expired) begin
                    if (st_reg.beat == st_reg.last) begin
                        st_next.cs = 1'b0; // RQ9
                        st_next.oe = 1'b0;
                        st_next.state = FTP_DONE;
                    end else begin
                        st_next.beat = st_reg.beat + BW'(1);
                        st_next.fl_addr = st_reg.base + ADDR_W'(st_next.beat);
                        for (int b = 0; b < BEATS; b++) begin
                            if (st_next.beat == BW'(b)) begin
                                st_next.fl_dq = st_reg.wdata[b*DATA_W +: DATA_W];
                            end
                        end
                        st_next.state = FTP_SETUP;
                        tif.load = 1'b1;
                        tif.count = SETUP_C; // RQ7
                    end
                end
            end
            FTP_DONE: begin
                st_next.rvalid = !st_reg.is_wr; // RQ2
                st_next.state = FTP_IDLE;
            end
            default: begin
                st_next.state = FTP_IDLE;
                st_next.cs = 1'b0;
                st_next.rd = 1'b0;
                st_next.wr = 1'b0;
                st_next.oe = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_SYS_RST) st_reg <= '0;
        else st_reg <= st_next;
    end

    // request held until the access completes
    assign O_WAITREQ = (st_reg.state != FTP_DONE) && (I_READ || I_WRITE);
    assign O_RVALID = st_reg.rvalid;
    assign O_RDATA = st_reg.rdata;
    assign O_FL_ADDR = st_reg.fl_addr; // RQ3 RQ11
    assign O_FL_DQ = st_reg.fl_dq; // RQ4
    assign O_FL_DQ_OE = st_reg.oe;
    assign O_FL_CS_N = !st_reg.cs; // RQ11
    assign O_FL_RD_N = !st_reg.rd;
    assign O_FL_WR_N = !st_reg.wr;
endmodule : ftp_port

/* File: ftp_flash_model.sv */
// behavioural parallel flash on the shared tristate bus, 16 bytes deep
// assumes the bench resolves the data wire from the port's output enable
`timescale 1ns/1ps
module ftp_flash_model (
    input wire logic i_cs_n,
    input wire logic i_rd_n,
    input wire logic i_wr_n,
    input wire logic [21:0] i_addr,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq
);
    logic [7:0] mem [0:15];
    logic [7:0] last;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = 8'hFF;
        last = 8'h00;
    end
    // byte stored while write strobe and select are low
    always @(i_dq, i_addr, i_wr_n, i_cs_n) begin
        if (!i_cs_n && !i_wr_n) mem[i_addr[3:0]] = i_dq;
    end
    // remember the byte last put on the bus
    always @(i_cs_n, i_rd_n, i_addr) begin
        if (!i_cs_n && !i_rd_n) last = mem[i_addr[3:0]];
    end
    // released bus shows the inverse of the last driven byte
    assign o_dq = (!i_cs_n && !i_rd_n) ? mem[i_addr[3:0]] : ~last;
endmodule : ftp_flash_model

/* File: ftp_port_checker.sv */
// timing checks on the flash strobes, default timing of one, four, one cycles
// assumes default width and timing parameters on the bound port
`timescale 1ns/1ps
module ftp_port_checker (
    input wire logic I_CORE_CLK,
    input wire logic I_SYS_RST,
    input wire logic O_WAITREQ,
    input wire logic O_RVALID,
    input wire logic O_FL_DQ_OE,
    input wire logic O_FL_CS_N,
    input wire logic O_FL_RD_N,
    input wire logic O_FL_WR_N
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_SYS_RST);
    a_setup_before_strobe: assert property ($fell(O_FL_CS_N) |-> O_FL_RD_N && O_FL_WR_N
        ##1 ($fell(O_FL_RD_N) || $fell(O_FL_WR_N))) else $error("strobe setup wrong");
    a_read_strobe_len: assert property ($fell(O_FL_RD_N) |-> !O_FL_RD_N [*4] ##1 O_FL_RD_N)
        else $error("read strobe length wrong");
    a_write_strobe_len: assert property ($fell(O_FL_WR_N) |-> !O_FL_WR_N [*4] ##1 O_FL_WR_N)
        else $error("write strobe length wrong");
    a_hold_after_write: assert property ($rose(O_FL_WR_N) |-> !O_FL_CS_N)
        else $error("select released without hold");
    a_strobe_needs_select: assert property (!(O_FL_RD_N && O_FL_WR_N) |-> !O_FL_CS_N
        && (O_FL_RD_N || O_FL_WR_N)) else $error("strobe outside select");
    a_four_beat_access: assert property ($fell(O_FL_CS_N) |-> ##24 ($rose(O_FL_CS_N)
        && !O_WAITREQ)) else $error("access length wrong");
    a_rvalid_ends_wait: assert property (O_RVALID |-> !$past(O_WAITREQ) && !$past(O_FL_CS_N, 2))
        else $error("read data before access end");
    a_drive_on_write: assert property (!O_FL_WR_N |-> O_FL_DQ_OE)
        else $error("write data not driven");
    a_float_on_read: assert property (!O_FL_RD_N |-> !O_FL_DQ_OE)
        else $error("bus driven during read");
    c_read: cover property (O_RVALID);
    c_write: cover property ($rose(O_FL_WR_N));
    c_read_strobe: cover property ($rose(O_FL_RD_N));
endmodule : ftp_port_checker
bind ftp_port ftp_port_checker ftp_port_checker_inst (.I_CORE_CLK, .I_SYS_RST, .O_WAITREQ,
    .O_RVALID, .O_FL_DQ_OE, .O_FL_CS_N, .O_FL_RD_N, .O_FL_WR_N);

/* File: testbench.sv */
// self-checking bench for the flash tristate port with a behavioural flash
// assumes default port parameters: 32-bit host, 8-bit flash, 1/4/1 cycle timing
`timescale 1ns/1ps
module testbench;
    import ftp_pkg::*;
    typedef struct {logic rd; logic wr; logic [21:0] a; logic [31:0] d; logic [3:0] be;} ftp_row_type;
    logic clk = 0, rst = 1, rd = 0, wr = 0;
    logic [21:0] addr = 22'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic [3:0] be = 4'h0;
    logic waitreq, rvalid, oe, cs_n, rd_n, wr_n;
    logic [21:0] fl_addr;
    logic [7:0] dq_out, dq_model;
    wire [7:0] dq = oe ? dq_out : dq_model;
    int fail_count = 0, n_compared = 0;
    ftp_row_type rows [6] = '{'{0, 1, 22'h0, 32'h44332211, 4'hF}, '{0, 1, 22'h4, 32'hA5C3F00F, 4'hF},
        '{1, 0, 22'h0, 32'h44332211, 4'h0}, '{1, 0, 22'h6, 32'hA5C3F00F, 4'h0},
        '{1, 0, 22'h8, 32'hFFFFFFFF, 4'h0}, '{1, 1, 22'h4, 32'hA5C3F00F, 4'hF}};
    ftp_port ftp_port_inst (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_ADDR(addr), .I_READ(rd),
        .I_WRITE(wr), .I_WDATA(wdata), .I_BE(be), .O_RDATA(rdata), .O_WAITREQ(waitreq),
        .O_RVALID(rvalid), .O_FL_ADDR(fl_addr), .O_FL_DQ(dq_out), .O_FL_DQ_OE(oe),
        .I_FL_DQ(dq), .O_FL_CS_N(cs_n), .O_FL_RD_N(rd_n), .O_FL_WR_N(wr_n));
    ftp_flash_model ftp_flash_model_inst (.i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_addr(fl_addr), .i_dq(dq), .o_dq(dq_model));
    initial forever #20 clk = ~clk;
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic access(input ftp_row_type r, output logic [31:0] res);
        @(posedge clk) #1;
        {rd, wr, addr, wdata, be} = {r.rd, r.wr, r.a, r.d, r.be};
        for (int n = 0; n < 100; n++) begin
            @(posedge clk);
            if (waitreq === 1'b0) break;
        end
        check("waitreq", waitreq, 32'h0);
        res = rdata;
        #1 {rd, wr} = 2'b00;
        @(posedge clk);
        check("rvalid", rvalid, r.rd);
    endtask : access
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : final_report
    initial begin
        #(40 * 3000);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk);
        #1 rst = 0;
        check("reset rdata", rdata, 32'h0);
        check("reset pins", {cs_n, rd_n, wr_n, oe, rvalid}, 5'h1C);
        $display("test reset done");
        foreach (rows[i]) begin
            access(rows[i], q);
            if (rows[i].rd) check("read data", q, rows[i].d);
            $display("test row %0d done", i);
        end
        check("lane order", ftp_flash_model_inst.mem[4], 32'h0F);
        access('{0, 1, 22'h1, 32'hDDCCBBAA, 4'h5}, q);
        access('{1, 0, 22'h3, 32'h0, 4'h0}, q);
        check("masked write", q, 32'h44CC22AA);
        $display("test byte enables done");
        check("cycles ns exact", ftp_cycles(UNIT_NS, 40), 32'h1);
        check("cycles ns round", ftp_cycles(UNIT_NS, 41), 32'h2);
        check("cycles us", ftp_cycles(UNIT_US, 1), 32'h19);
        check("cycles ms", ftp_cycles(UNIT_MS, 1), 32'h61A8);
        check("cycles clk", ftp_cycles(UNIT_CYC, 3), 32'h3);
        $display("test unit conversion done");
        @(posedge clk) #1;
        {wr, addr, wdata, be} = {1'b1, 22'hC, 32'hFFFFFFFF, 4'hF};
        repeat (4) @(posedge clk);
        #1 rst = 1;
        wr = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst = 0;
        check("cut reset pins", {cs_n, rd_n, wr_n, oe, rvalid}, 5'h1C);
        access('{1, 0, 22'hC, 32'h0, 4'h0}, q);
        check("read after cut", q, 32'hFFFFFFFF);
        $display("test mid-run reset done");
        final_report();
    end
endmodule : testbench
